/* File: common/msc_defs.svh */
// Purpose: Constants for the bulk-only mass storage framer
// Assumes: Byte-wide endpoint streams
// Notes:   Offsets and codes as used on the wire
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_CBW_SIG     32'h43425355
`define MSC_CSW_SIG     32'h53425355
`define MSC_CBW_LEN     5'h1F
`define MSC_CSW_LEN     5'h0D
`define MSC_OFS_TAG     5'h04
`define MSC_OFS_LEN     5'h08
`define MSC_OFS_FLAGS   5'h0C
`define MSC_OFS_LUN     5'h0D
`define MSC_OFS_CBLEN   5'h0E
`define MSC_OFS_CB      5'h0F
`define MSC_DIR_BIT     7
`define MSC_ST_PASS     8'h00
`define MSC_ST_FAIL     8'h01
`define MSC_ST_PHASE    8'h02
`define MSC_REQ_MAXLUN  8'hFE
`define MSC_REQ_RESET   8'hFF
`define MSC_RT_CLASS    2'h1
`define MSC_SUBCLASS    8'h06
`define MSC_EP_CTRL     4'h0
`define MSC_EP_BULK_OUT 4'h1
`define MSC_MAX_LUN     8'h01
`define MSC_IFACE       16'h0000
`define MSC_FIFO_W      8
`define MSC_FIFO_D      32
`endif

/* File: common/msc_pkg.sv */
// Purpose: Types for the bulk-only mass storage framer
// Assumes: Nothing
// Notes:   Command descriptor handed to the command executor
`default_nettype none
package msc_pkg;
    typedef enum logic [1:0] {ST_CBW, ST_CHECK, ST_DATA, ST_CSW} msc_state_e;
    typedef struct packed {
        logic [31:0]  tag;
        logic [31:0]  len;
        logic         dir;
        logic [3:0]   lun;
        logic [4:0]   cblen;
        logic [127:0] cb;
    } msc_cmd_s;
    typedef struct packed {
        logic [7:0]  rtype;
        logic [7:0]  req;
        logic [15:0] index;
    } msc_setup_s;
endpackage : msc_pkg
`default_nettype wire

/* File: rtl/msc_bot_framer.sv */
// Purpose: Bulk-only transport command/data/status framer, device side
// Assumes: Device controller presents endpoint bytes with endpoint number
// Notes:   Data-in bytes are buffered in a 32-byte FIFO
//
// What this block does
// - Endpoints are a 0..15 number plus direction IN or OUT.
// - Endpoint 0 always exists and carries control transfers.
// - Commands and data out share bulk OUT endpoint 1; data in and status share bulk IN.
// - Command, data and status all travel on bulk transfers only.
// - Data phase uses bulk IN to host, bulk OUT from host.
// - Status wrapper returns to host on bulk IN.
// - Wrapper bytes: signature, tag, length, flags, unit, cb length, cb.
// - Command signature is 0x43425355, least significant byte first.
// - Host tag is echoed unchanged into the status wrapper.
// - Transfer length counts data bytes; zero means no data phase.
// - Flags bit 7 picks direction: 0 OUT, 1 IN.
// - Logical unit field routes the command to one drive.
// - Status wrapper bytes: signature, tag, residue, status code.
// - Status signature is 0x53425355, least significant byte first.
// - Residue holds untransferred bytes, else zero.
// - Status is 0x00 pass, 0x01 fail, 0x02 phase error only.
// - Subclass code 0x06, SCSI transparent command set.
// - Command block is passed on as a SCSI command.
// - Only requests addressed to this interface are answered.
// - Request 0xFE returns the highest logical unit number.
// - Request 0xFF resets the interface and any command in flight.
`default_nettype none
`include "msc_defs.svh"

module msc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         flush,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [0:D-1];
    logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next, cnt;
    logic         rdy_reg, rdy_next, push, pop;

    assign push      = in_valid & rdy_reg;
    assign pop       = out_valid & out_ready;
    assign out_valid = (wp_reg != rp_reg);
    assign out_data  = mem[rp_reg[AW-1:0]];
    assign in_ready  = rdy_reg;

    // Ready is a flop, so it drops one slot early to never overrun
    always_comb begin
        wp_next  = flush ? '0 : wp_reg + (AW+1)'(push);
        rp_next  = flush ? '0 : rp_reg + (AW+1)'(pop);
        cnt      = wp_next - rp_next;
        rdy_next = cnt < (AW+1)'(D - 1);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            rdy_reg <= 1'b0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            rdy_reg <= rdy_next;
        end
    end
endmodule : msc_fifo

module msc_bot_framer (
    input  wire logic                CLK,
    input  wire logic                ARST_N,
    input  wire logic [3:0]          OUT_EP,
    input  wire logic                OUT_VALID,
    input  wire logic [7:0]          OUT_DATA,
    input  wire logic                OUT_LAST,
    output var  logic                OUT_READY,
    output var  logic                IN_VALID,
    output var  logic [7:0]          IN_DATA,
    output var  logic                IN_LAST,
    input  wire logic                IN_READY,
    input  wire logic                SETUP_VALID,
    input  wire logic [3:0]          SETUP_EP,
    input  wire msc_pkg::msc_setup_s SETUP,
    output var  logic                MAXLUN_VALID,
    output var  logic [7:0]          MAXLUN_DATA,
    output var  logic [7:0]          SUBCLASS,
    output var  logic                CMD_VALID,
    output var  msc_pkg::msc_cmd_s   CMD,
    output var  logic                BAD_CBW,
    output var  logic                WR_VALID,
    output var  logic [7:0]          WR_DATA,
    input  wire logic                WR_READY,
    input  wire logic                RD_VALID,
    input  wire logic [7:0]          RD_DATA,
    output var  logic                RD_READY,
    input  wire logic                EXEC_DONE,
    input  wire logic [7:0]          EXEC_STATUS
);
    msc_pkg::msc_state_e state_reg, state_next;
    msc_pkg::msc_cmd_s   cmd_reg, cmd_next;
    logic [7:0]  cbw_reg [0:30];
    logic [7:0]  cbw_next [0:30];
    logic [4:0]  ix_reg, ix_next;
    logic [3:0]  pos_reg, pos_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [7:0]  stat_reg, stat_next, ind_reg, ind_next, wrd_reg, wrd_next;
    logic        over_reg, over_next, done_reg, done_next, cmdv_reg, cmdv_next;
    logic        bad_reg, bad_next, inv_reg, inv_next, inl_reg, inl_next;
    logic        wrv_reg, wrv_next, ordy_reg, ordy_next, lunv_reg, lunv_next;
    logic        ob, fpop, fifo_v, setup_ok;
    logic [7:0]  fifo_d;

    function automatic logic [31:0] le32(input logic [4:0] b);
        return {cbw_reg[b + 5'h3], cbw_reg[b + 5'h2], cbw_reg[b + 5'h1], cbw_reg[b]};
    endfunction : le32

    function automatic logic [7:0] csw_byte(input logic [3:0] k);
        logic [31:0] w;
        w = (k < 4'h4) ? `MSC_CSW_SIG : (k < 4'h8) ? cmd_reg.tag : cmd_reg.len - cnt_reg;
        return (k == 4'hC) ? stat_reg : w[8 * k[1:0] +: 8];
    endfunction : csw_byte

    // Data-in bytes from the executor, drained toward bulk IN
    msc_fifo #(.W(`MSC_FIFO_W), .D(`MSC_FIFO_D)) u_fifo (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .flush     (state_reg == msc_pkg::ST_CBW),
        .in_valid  (RD_VALID),
        .in_data   (RD_DATA),
        .in_ready  (RD_READY),
        .out_valid (fifo_v),
        .out_data  (fifo_d),
        .out_ready (fpop)
    );

    // Bytes on any other endpoint are not ours and are ignored
    assign ob       = OUT_VALID & ordy_reg & (OUT_EP == `MSC_EP_BULK_OUT);
    assign setup_ok = SETUP_VALID && SETUP_EP == `MSC_EP_CTRL
                      && SETUP.rtype[6:5] == `MSC_RT_CLASS && SETUP.index == `MSC_IFACE;

    // ----------------------------------------------------------------
    // Framer state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        cbw_next   = cbw_reg;
        ix_next    = ix_reg;
        pos_next   = pos_reg;
        cnt_next   = cnt_reg;
        stat_next  = stat_reg;
        over_next  = over_reg;
        done_next  = done_reg;
        ind_next   = ind_reg;
        inl_next   = inl_reg;
        wrd_next   = wrd_reg;
        inv_next   = inv_reg & ~IN_READY;
        wrv_next   = wrv_reg & ~WR_READY;
        cmdv_next  = 1'b0;
        bad_next   = 1'b0;
        lunv_next  = 1'b0;
        fpop       = 1'b0;
        if (EXEC_DONE) begin
            done_next = 1'b1;
            // Reserved codes never leave the block
            stat_next = (EXEC_STATUS > `MSC_ST_PHASE) ? `MSC_ST_PHASE : EXEC_STATUS;
        end
        case (state_reg)
            msc_pkg::ST_CBW: begin
                if (ob) begin
                    if (ix_reg < `MSC_CBW_LEN) begin
                        cbw_next[ix_reg] = OUT_DATA;
                        ix_next          = ix_reg + 5'h1;
                    end else begin
                        over_next = 1'b1;
                    end
                    if (OUT_LAST) begin
                        state_next = msc_pkg::ST_CHECK;
                    end
                end
            end
            msc_pkg::ST_CHECK: begin
                ix_next   = '0;
                over_next = 1'b0;
                if (!over_reg && ix_reg == `MSC_CBW_LEN
                    && le32('0) == `MSC_CBW_SIG) begin
                    cmd_next.tag   = le32(`MSC_OFS_TAG);
                    cmd_next.len   = le32(`MSC_OFS_LEN);
                    cmd_next.dir   = cbw_reg[`MSC_OFS_FLAGS][`MSC_DIR_BIT];
                    cmd_next.lun   = cbw_reg[`MSC_OFS_LUN][3:0];
                    cmd_next.cblen = cbw_reg[`MSC_OFS_CBLEN][4:0];
                    for (int i = 0; i < 16; i++) begin
                        cmd_next.cb[8*i +: 8] = cbw_reg[`MSC_OFS_CB + 5'(i)];
                    end
                    cmdv_next  = 1'b1;
                    cnt_next   = '0;
                    done_next  = 1'b0;
                    state_next = msc_pkg::ST_DATA;
                end else begin
                    bad_next   = 1'b1;
                    state_next = msc_pkg::ST_CBW;
                end
            end
            msc_pkg::ST_DATA: begin
                // Byte count capped at the length; zero length moves nothing
                if (cmd_reg.dir) begin
                    if (fifo_v && cnt_reg < cmd_reg.len && (!inv_reg || IN_READY)) begin
                        fpop     = 1'b1;
                        inv_next = 1'b1;
                        ind_next = fifo_d;
                        inl_next = 1'b0;
                        cnt_next = cnt_reg + 32'h1;
                    end
                end else if (ob && cnt_reg < cmd_reg.len) begin
                    wrv_next = 1'b1;
                    wrd_next = OUT_DATA;
                    cnt_next = cnt_reg + 32'h1;
                end
                if (done_reg && !wrv_reg && !inv_reg) begin
                    ix_next    = '0;
                    state_next = msc_pkg::ST_CSW;
                end
            end
            msc_pkg::ST_CSW: begin
                if (inv_reg && IN_READY && inl_reg) begin
                    ix_next    = '0;
                    state_next = msc_pkg::ST_CBW;
                end else if ((!inv_reg || IN_READY) && ix_reg < `MSC_CSW_LEN) begin
                    inv_next = 1'b1;
                    ind_next = csw_byte(ix_reg[3:0]);
                    pos_next = ix_reg[3:0];
                    inl_next = (ix_reg == `MSC_CSW_LEN - 5'h1);
                    ix_next  = ix_reg + 5'h1;
                end
            end
            default: begin
                state_next = msc_pkg::ST_CBW;
            end
        endcase
        if (setup_ok && SETUP.req == `MSC_REQ_MAXLUN) begin
            lunv_next = 1'b1;
        end
        if (setup_ok && SETUP.req == `MSC_REQ_RESET) begin
            state_next = msc_pkg::ST_CBW;
            ix_next    = '0;
            over_next  = 1'b0;
            done_next  = 1'b0;
            inv_next   = 1'b0;
            wrv_next   = 1'b0;
            cmdv_next  = 1'b0;
        end
        // Registered ready: in the data phase one accept, then a gap while the byte drains
        ordy_next = (state_next == msc_pkg::ST_CBW)
                    || (state_next == msc_pkg::ST_DATA && !cmd_next.dir
                        && cnt_next < cmd_next.len && !wrv_next && !ob);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= msc_pkg::ST_CBW;
            cmd_reg   <= '0;
            cbw_reg   <= '{default: 8'h00};
            ix_reg    <= '0;
            pos_reg   <= '0;
            cnt_reg   <= '0;
            stat_reg  <= `MSC_ST_PASS;
            over_reg  <= 1'b0;
            done_reg  <= 1'b0;
            ind_reg   <= '0;
            inl_reg   <= 1'b0;
            inv_reg   <= 1'b0;
            wrd_reg   <= '0;
            wrv_reg   <= 1'b0;
            cmdv_reg  <= 1'b0;
            bad_reg   <= 1'b0;
            lunv_reg  <= 1'b0;
            ordy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            cbw_reg   <= cbw_next;
            ix_reg    <= ix_next;
            pos_reg   <= pos_next;
            cnt_reg   <= cnt_next;
            stat_reg  <= stat_next;
            over_reg  <= over_next;
            done_reg  <= done_next;
            ind_reg   <= ind_next;
            inl_reg   <= inl_next;
            inv_reg   <= inv_next;
            wrd_reg   <= wrd_next;
            wrv_reg   <= wrv_next;
            cmdv_reg  <= cmdv_next;
            bad_reg   <= bad_next;
            lunv_reg  <= lunv_next;
            ordy_reg  <= ordy_next;
        end
    end

    assign OUT_READY    = ordy_reg;
    assign IN_VALID     = inv_reg;
    assign IN_DATA      = ind_reg;
    assign IN_LAST      = inl_reg;
    assign WR_VALID     = wrv_reg;
    assign WR_DATA      = wrd_reg;
    assign CMD_VALID    = cmdv_reg;
    assign CMD          = cmd_reg;
    assign BAD_CBW      = bad_reg;
    assign MAXLUN_VALID = lunv_reg;
    assign MAXLUN_DATA  = `MSC_MAX_LUN;
    assign SUBCLASS     = `MSC_SUBCLASS;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    property p_reject;
        state_reg == msc_pkg::ST_CHECK && le32('0) != `MSC_CBW_SIG
            |=> !CMD_VALID && BAD_CBW && state_reg == msc_pkg::ST_CBW;
    endproperty
    a_reject: assert property (p_reject) else $error("bad wrapper accepted");
    property p_dir;
        CMD_VALID |-> CMD.dir == $past(cbw_reg[12][7]) && CMD.tag == $past(le32(5'h04));
    endproperty
    a_dir: assert property (p_dir) else $error("direction or tag wrong");
    property p_csw_sig;
        IN_VALID && state_reg == msc_pkg::ST_CSW && pos_reg == 4'h0 |-> IN_DATA == 8'h55;
    endproperty
    a_csw_sig: assert property (p_csw_sig) else $error("status signature wrong");
    property p_tag;
        IN_VALID && state_reg == msc_pkg::ST_CSW && pos_reg == 4'h4 |-> IN_DATA == CMD.tag[7:0];
    endproperty
    a_tag: assert property (p_tag) else $error("tag not echoed");
    property p_status;
        IN_VALID && IN_LAST && state_reg == msc_pkg::ST_CSW |-> pos_reg == 4'hC && IN_DATA < 8'h03;
    endproperty
    a_status: assert property (p_status) else $error("bad status byte");
    property p_residue;
        IN_VALID && state_reg == msc_pkg::ST_CSW && pos_reg == 4'h8
            |-> IN_DATA == 8'(CMD.len - cnt_reg) && cnt_reg <= CMD.len;
    endproperty
    a_residue: assert property (p_residue) else $error("residue wrong");
    property p_reset;
        setup_ok && SETUP.req == `MSC_REQ_RESET |=> state_reg == msc_pkg::ST_CBW && !IN_VALID;
    endproperty
    a_reset: assert property (p_reset) else $error("reset request ignored");
    property p_maxlun;
        setup_ok && SETUP.req == `MSC_REQ_MAXLUN |=> MAXLUN_VALID ##1 !MAXLUN_VALID;
    endproperty
    a_maxlun: assert property (p_maxlun) else $error("max unit not answered");
endmodule : msc_bot_framer
`default_nettype wire

/* File: testbench/msc_host_model.sv */
// Purpose: Host side of the bulk endpoints for the framer bench
// Assumes: Called at 1ns after a rising CLK edge
// Notes:   Released endpoint and data lines show the inverse of their last value
`default_nettype none
module msc_host_model (
    input  wire logic       clk,
    output var  logic [3:0] out_ep,
    output var  logic       out_valid,
    output var  logic [7:0] out_data,
    output var  logic       out_last,
    input  wire logic       out_ready,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    input  wire logic       in_last,
    output var  logic       in_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_d[$];
    logic       rx_l[$];
    int         hang;
    initial begin
        out_ep = 4'h0;
        out_valid = 1'b0;
        out_data = 8'h00;
        out_last = 1'b0;
        in_ready = 1'b0;
        hang = 0;
    end
    // -------------------------------------------------------------
    // Transfers
    // -------------------------------------------------------------
    // Commands and data out both go on bulk OUT only
    task automatic send_byte(input logic [3:0] ep, input logic [7:0] d, input logic l);
        int n;
        n = 0;
        out_ep = ep;
        out_valid = 1'b1;
        out_data = d;
        out_last = l;
        while (!out_ready && n < 200) begin
            @(posedge clk) #1;
            n++;
        end
        if (n >= 200) hang++;
        @(posedge clk) #1;
    endtask : send_byte
    task automatic idle_out();
        out_valid = 1'b0;
        out_last = 1'b0;
        out_ep = ~out_ep;
        out_data = ~out_data;
    endtask : idle_out
    // Data in and status come back on bulk IN; slow mode stalls
    task automatic recv(input int cnt, input logic slow);
        int n;
        in_ready = 1'b1;
        for (int k = 0; k < cnt; k++) begin
            n = 0;
            while (!in_valid && n < 200) begin
                @(posedge clk) #1;
                n++;
            end
            if (n >= 200) hang++;
            rx_d.push_back(in_data);
            rx_l.push_back(in_last);
            @(posedge clk) #1;
            if (slow && k < cnt - 1) begin
                in_ready = 1'b0;
                repeat (3) @(posedge clk) #1;
                in_ready = 1'b1;
            end
        end
        in_ready = 1'b0;
    endtask : recv
endmodule : msc_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the bulk-only framer
// Assumes: Bench plays the command executor, host model the host
// Notes:   Inputs change 1ns after the rising edge
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, arst_n, out_valid, out_last, out_ready, in_valid, in_last, in_ready;
    logic setup_valid, maxlun_valid, cmd_valid, bad_cbw, wr_valid, wr_ready;
    logic rd_valid, rd_ready, exec_done;
    logic [3:0] out_ep, setup_ep;
    logic [7:0] out_data, in_data, maxlun_data, subclass, wr_data, rd_data, exec_status;
    msc_pkg::msc_setup_s setup;
    msc_pkg::msc_cmd_s   cmd;
    int errors, samples_checked, cycles;
    msc_bot_framer dut_u (.CLK(clk), .ARST_N(arst_n), .OUT_EP(out_ep),
        .OUT_VALID(out_valid), .OUT_DATA(out_data), .OUT_LAST(out_last),
        .OUT_READY(out_ready), .IN_VALID(in_valid), .IN_DATA(in_data), .IN_LAST(in_last),
        .IN_READY(in_ready), .SETUP_VALID(setup_valid), .SETUP_EP(setup_ep), .SETUP(setup),
        .MAXLUN_VALID(maxlun_valid), .MAXLUN_DATA(maxlun_data), .SUBCLASS(subclass),
        .CMD_VALID(cmd_valid), .CMD(cmd), .BAD_CBW(bad_cbw), .WR_VALID(wr_valid),
        .WR_DATA(wr_data), .WR_READY(wr_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
        .RD_READY(rd_ready), .EXEC_DONE(exec_done), .EXEC_STATUS(exec_status));
    msc_host_model host_u (.clk(clk), .out_ep(out_ep), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
        .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready));
    always #12.5 clk = ~clk;
    // Whole run needs a few hundred cycles; ceiling leaves margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic send_cbw(input logic [31:0] sig, input logic [31:0] tag,
                            input logic [31:0] len, input logic [7:0] flg, input int nb);
        logic [7:0] b[32];
        for (int i = 0; i < 4; i++) begin
            b[i] = sig[8*i +: 8];
            b[4+i] = tag[8*i +: 8];
            b[8+i] = len[8*i +: 8];
        end
        b[12] = flg;                  // Low flag bits kept clear
        b[13] = 8'h03;
        b[14] = 8'h06;
        b[31] = 8'h00;
        for (int i = 0; i < 16; i++) b[15+i] = 8'hC0 + 8'(i);
        for (int i = 0; i < nb; i++) host_u.send_byte(4'h1, b[i], i == nb - 1);
        host_u.idle_out();
    endtask : send_cbw
    task automatic chk_cmd(input logic [31:0] tag, input logic [31:0] len, input logic dir);
        @(posedge clk) #1;
        check(cmd_valid, 1'b1);
        check(bad_cbw, 1'b0);
        check(cmd.tag, tag);
        check(cmd.len, len);
        check(cmd.dir, dir);
        check(cmd.lun, 4'h3);
        check(cmd.cblen, 5'h06);
        check(cmd.cb, 128'hCFCECDCCCBCAC9C8C7C6C5C4C3C2C1C0);
        @(posedge clk) #1;
        check(cmd_valid, 1'b0);
    endtask : chk_cmd
    task automatic chk_csw(input logic [31:0] tag, input logic [31:0] res, input logic [7:0] st);
        logic [103:0] e;
        e = {st, res, tag, 32'h53425355};
        host_u.rx_d.delete();
        host_u.rx_l.delete();
        host_u.recv(13, 1'b0);
        for (int i = 0; i < 13; i++) begin
            check(host_u.rx_d[i], e[8*i +: 8]);
            check(host_u.rx_l[i], i == 12);
        end
    endtask : chk_csw
    task automatic finish_cmd(input logic [7:0] st);
        exec_status = st;
        exec_done = 1'b1;
        @(posedge clk) #1;
        exec_done = 1'b0;
    endtask : finish_cmd
    task automatic setup_req(input logic [3:0] ep, input logic [7:0] rt, input logic [7:0] rq,
                             input int exp);
        int c;
        c = 0;
        setup_ep = ep;
        setup = {rt, rq, 16'h0000};
        setup_valid = 1'b1;
        @(posedge clk) #1;
        setup_valid = 1'b0;
        repeat (4) begin
            if (maxlun_valid) c++;
            @(posedge clk) #1;
        end
        check(c, exp);
    endtask : setup_req
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_data_in();
        int n, low;
        n = 0;
        low = 0;
        host_u.send_byte(4'h2, 8'hEE, 1'b1);  // Foreign endpoint ignored
        send_cbw(32'h43425355, 32'hA1B2C3D4, 32'd40, 8'h80, 31);
        chk_cmd(32'hA1B2C3D4, 32'd40, 1'b1);
        rd_valid = 1'b1;
        while (low < 4 && n < 40) begin
            rd_data = 8'(n);
            if (rd_ready) n++;
            else low++;
            @(posedge clk) #1;
        end
        rd_valid = 1'b0;
        rd_data = ~rd_data;
        check(rd_ready, 1'b0);  // Host stalled, buffer refuses
        host_u.rx_d.delete();
        host_u.recv(n, 1'b1);
        for (int k = 0; k < n; k++) check(host_u.rx_d[k], 8'(k));
        finish_cmd(8'h00);
        chk_csw(32'hA1B2C3D4, 32'd40 - 32'(n), 8'h00);  // Short despite pass
    endtask : t_data_in
    task automatic t_data_out();
        send_cbw(32'h43425355, 32'h0F1E2D3C, 32'd4, 8'h00, 31);
        chk_cmd(32'h0F1E2D3C, 32'd4, 1'b0);
        fork
            begin
                for (int i = 0; i < 4; i++) host_u.send_byte(4'h1, 8'h50 + 8'(i), 1'b0);
                host_u.idle_out();
            end
            for (int k = 0; k < 4; k++) begin
                repeat (2) @(posedge clk) #1;
                wr_ready = 1'b1;
                for (int n = 0; n < 200 && !wr_valid; n++) @(posedge clk) #1;
                check(wr_data, 8'h50 + 8'(k));
                @(posedge clk) #1;
                wr_ready = 1'b0;
            end
        join
        finish_cmd(8'h07);
        chk_csw(32'h0F1E2D3C, 32'd0, 8'h02);  // Reserved code sent as phase error
    endtask : t_data_out
    task automatic t_bad();
        send_cbw(32'h43425356, 32'h11111111, 32'd0, 8'h00, 31);
        @(posedge clk) #1;
        check(bad_cbw, 1'b1);
        check(cmd_valid, 1'b0);
        repeat (4) @(posedge clk) #1;
        // One byte short, then one byte too many
        for (int nb = 30; nb <= 32; nb += 2) begin
            send_cbw(32'h43425355, 32'h22222222, 32'd0, 8'h00, nb);
            @(posedge clk) #1;
            check(bad_cbw, 1'b1);
            check(cmd_valid, 1'b0);
            repeat (4) @(posedge clk) #1;
        end
    endtask : t_bad
    task automatic t_ctrl();
        check(subclass, 8'h06);
        check(maxlun_data, 8'h01);
        setup_req(4'h0, 8'hA1, 8'hFE, 1);
        setup_req(4'h2, 8'hA1, 8'hFE, 0);
        setup_req(4'h0, 8'h80, 8'hFE, 0);
        send_cbw(32'h43425355, 32'h33333333, 32'd8, 8'h80, 31);
        repeat (4) @(posedge clk) #1;
        setup_req(4'h0, 8'h21, 8'hFF, 0);
        send_cbw(32'h43425355, 32'h44444444, 32'd0, 8'h00, 31);
        chk_cmd(32'h44444444, 32'd0, 1'b0);
        finish_cmd(8'h01);
        chk_csw(32'h44444444, 32'd0, 8'h01);
    endtask : t_ctrl
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        setup_valid = 1'b0;
        setup_ep = 4'h0;
        setup = '0;
        wr_ready = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
        exec_done = 1'b0;
        exec_status = 8'h00;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (2) @(posedge clk) #1;
        t_data_in();
        t_data_out();
        t_bad();
        t_ctrl();
        check(host_u.hang, 0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
